// [rtl/cse_pkg.sv]
package cse_pkg;

   // clock and timing
   localparam logic [63:0] CLK_HZ          = 64'h0000_0000_0773_5940;
   localparam logic [63:0] SAFETY_TIME_S   = 64'h0000_0000_0000_3840;
   localparam logic [63:0] BAD_TIME_S      = 64'h0000_0000_0000_0708;
   localparam logic [63:0] SAFETY_CYCLES   = SAFETY_TIME_S * CLK_HZ;
   localparam logic [63:0] BAD_CYCLES      = BAD_TIME_S * CLK_HZ;

   // carrier and blink
   localparam logic [63:0] CARRIER_HZ      = 64'h0000_0000_0000_88b8;
   localparam logic [63:0] DUTY_STEPS      = 64'h0000_0000_0000_0010;
   localparam logic [63:0] SLOT_CYCLES     = CLK_HZ / (CARRIER_HZ * DUTY_STEPS);
   localparam logic [63:0] TEMP_BLINK_MHZ  = 64'h0000_0000_0000_05dc;
   localparam logic [63:0] BAD_BLINK_MHZ   = 64'h0000_0000_0000_17d4;
   localparam logic [63:0] MHZ_PER_HZ      = 64'h0000_0000_0000_03e8;
   localparam logic [63:0] TEMP_HALF_CYCLES = (CLK_HZ * MHZ_PER_HZ) / (64'h2 * TEMP_BLINK_MHZ);
   localparam logic [63:0] BAD_HALF_CYCLES  = (CLK_HZ * MHZ_PER_HZ) / (64'h2 * BAD_BLINK_MHZ);
   localparam logic [3:0]  TEMP_DUTY_LO    = 4'h1;
   localparam logic [3:0]  TEMP_DUTY_HI    = 4'hf;
   localparam logic [3:0]  BAD_DUTY_LO     = 4'h2;
   localparam logic [3:0]  BAD_DUTY_HI     = 4'he;

   // widths
   localparam int          TIMER_W         = 42;
   localparam int          BLINK_W         = 32;
   localparam int          SLOT_W          = 8;

   // register map
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_STATUS      = 8'h04;
   localparam logic [7:0]  REG_TIMER       = 8'h08;
   localparam logic        CTRL_HOLD_RESET = 1'h0;
   localparam int          CTRL_HOLD_BIT   = 0;
   localparam int          ST_STATE_LSB    = 0;
   localparam int          ST_PIN_LSB      = 2;
   localparam int          ST_RELEASED_BIT = 4;
   localparam int          ST_BADLATCH_BIT = 5;
   localparam int          ST_TEMPFLT_BIT  = 6;
   localparam int          ST_CHARGE_BIT   = 7;
   localparam int          ST_TRICKLE_BIT  = 8;
   localparam int          ST_REDUCE_BIT   = 9;

   typedef struct packed {
      logic power_good;
      logic charger_suspend_input;
      logic vbat_below_trickle;
      logic current_below_tenth;
      logic hot_trip;
      logic cold_trip;
      logic thermistor_grounded;
      logic die_hot;
      logic cv_mode;
   } cse_sense_t;

   typedef enum logic [1:0] {
      CSE_IDLE,
      CSE_CHARGE,
      CSE_TERM,
      CSE_BAD
   } cse_state_t;

   typedef enum logic [1:0] {
      PIN_HIZ,
      PIN_LOW,
      PIN_TEMP,
      PIN_BAD
   } cse_pin_t;

endpackage

// [rtl/cse_top.sv]
// Contract
// - charge start drives status pin low
// - release pin below tenth current
// - fault after release keeps pin released
// - fault before release toggles pin 35kHz
// - temperature fault duty 1/16, 15/16, 1.5Hz
// - bad battery duty 2/16, 14/16, 6.1Hz
// - bad battery after half hour trickle
// - hot comparator pauses charge, temperature fault
// - cold comparator pauses charge, temperature fault
// - temperature pause in CV freezes timer
// - grounded thermistor input disables temperature logic
// - die hot requests current reduction
// - below trickle threshold use tenth current
// - bad latch cleared only by supply/suspend
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
module cse_top #(
   parameter logic [cse_pkg::TIMER_W-1:0] SAFETY_CYCLES_P = cse_pkg::SAFETY_CYCLES[cse_pkg::TIMER_W-1:0],
   parameter logic [cse_pkg::TIMER_W-1:0] BAD_CYCLES_P    = cse_pkg::BAD_CYCLES[cse_pkg::TIMER_W-1:0],
   parameter logic [cse_pkg::BLINK_W-1:0] TEMP_HALF_P     = cse_pkg::TEMP_HALF_CYCLES[cse_pkg::BLINK_W-1:0],
   parameter logic [cse_pkg::BLINK_W-1:0] BAD_HALF_P      = cse_pkg::BAD_HALF_CYCLES[cse_pkg::BLINK_W-1:0]
) (
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   // analog sense
   input  wire cse_pkg::cse_sense_t i_sense,
   // apb slave
   input  wire logic                i_psel,
   input  wire logic                i_penable,
   input  wire logic                i_pwrite,
   input  wire logic [7:0]          i_paddr,
   input  wire logic [31:0]         i_pwdata,
   output logic                     o_pready,
   output logic [31:0]              o_prdata,
   output logic                     o_pslverr,
   // open-drain status pin
   output logic                     o_charge_status_output_o,
   output logic                     o_charge_status_output_oe,
   // charger control
   output logic                     o_charge_on,
   output logic                     o_trickle_current,
   output logic                     o_current_reduce
);

   function automatic logic [3:0] cse_duty(input cse_pkg::cse_pin_t mode, input logic half);
      logic [3:0] d;
      d = 4'h0;
      if (mode == cse_pkg::PIN_TEMP) begin
         d = half ? cse_pkg::TEMP_DUTY_HI : cse_pkg::TEMP_DUTY_LO;
      end else if (mode == cse_pkg::PIN_BAD) begin
         d = half ? cse_pkg::BAD_DUTY_HI : cse_pkg::BAD_DUTY_LO;
      end
      return d;
   endfunction

   function automatic logic cse_reg_known(input logic [7:0] a);
      return (a == cse_pkg::REG_CTRL) || (a == cse_pkg::REG_STATUS) || (a == cse_pkg::REG_TIMER);
   endfunction

   localparam logic [cse_pkg::SLOT_W-1:0] SLOT_LAST = cse_pkg::SLOT_CYCLES[cse_pkg::SLOT_W-1:0] - 8'h01;

   // charger and pin state
   cse_pkg::cse_state_t             state;
   cse_pkg::cse_state_t             next_state;
   cse_pkg::cse_pin_t               pin_mode;
   cse_pkg::cse_pin_t               next_pin_mode;
   logic                            released;
   logic                            next_released;
   logic                            bad_latch;
   logic                            next_bad_latch;
   logic [cse_pkg::TIMER_W-1:0]     safety_cnt;
   logic [cse_pkg::TIMER_W-1:0]     next_safety_cnt;
   logic [cse_pkg::TIMER_W-1:0]     trickle_cnt;
   logic [cse_pkg::TIMER_W-1:0]     next_trickle_cnt;
   logic [cse_pkg::SLOT_W-1:0]      slot_cnt;
   logic [cse_pkg::SLOT_W-1:0]      next_slot_cnt;
   logic [3:0]                      step_cnt;
   logic [3:0]                      next_step_cnt;
   logic [cse_pkg::BLINK_W-1:0]     blink_cnt;
   logic [cse_pkg::BLINK_W-1:0]     next_blink_cnt;
   logic                            blink_half;
   logic                            next_blink_half;
   logic                            pin_oe;
   logic                            next_pin_oe;
   logic                            charge_on;
   logic                            next_charge_on;
   logic                            trickle_on;
   logic                            next_trickle_on;
   logic                            reduce_on;
   logic                            next_reduce_on;
   logic                            temp_fault;
   logic                            enabled;
   logic                            running;
   logic [cse_pkg::BLINK_W-1:0]     blink_last;

   // register state
   logic                            ctrl_hold;
   logic                            next_ctrl_hold;
   logic                            pready;
   logic                            next_pready;
   logic [31:0]                     prdata;
   logic [31:0]                     next_prdata;
   logic                            pslverr;
   logic                            next_pslverr;
   logic [31:0]                     status_word;

   always_comb begin
      temp_fault = !i_sense.thermistor_grounded && (i_sense.hot_trip || i_sense.cold_trip);
      enabled    = i_sense.power_good && !i_sense.charger_suspend_input;
      running    = !ctrl_hold && !temp_fault;
      next_state       = state;
      next_released    = released;
      next_bad_latch   = bad_latch;
      next_safety_cnt  = safety_cnt;
      next_trickle_cnt = trickle_cnt;
      case (state)
         cse_pkg::CSE_IDLE: begin
            // supply loss or suspend is the only way out of a bad latch
            next_bad_latch   = 1'b0;
            next_released    = 1'b0;
            next_safety_cnt  = '0;
            next_trickle_cnt = '0;
            if (enabled) begin
               next_state = cse_pkg::CSE_CHARGE;
            end
         end
         cse_pkg::CSE_CHARGE: begin
            if (!enabled) begin
               next_state = cse_pkg::CSE_IDLE;
            end else if (bad_latch && i_sense.vbat_below_trickle) begin
               next_state = cse_pkg::CSE_BAD;
            end else if (trickle_cnt >= BAD_CYCLES_P) begin
               next_state     = cse_pkg::CSE_BAD;
               next_bad_latch = 1'b1;
            end else if (safety_cnt >= SAFETY_CYCLES_P) begin
               next_state = cse_pkg::CSE_TERM;
            end else begin
               // timer freezes for a ctrl hold, or for a temperature pause in cv mode
               if (!ctrl_hold && !(temp_fault && i_sense.cv_mode)) begin
                  next_safety_cnt = safety_cnt + 1'b1;
               end
               if (!i_sense.vbat_below_trickle) begin
                  next_trickle_cnt = '0;
               end else if (running) begin
                  next_trickle_cnt = trickle_cnt + 1'b1;
               end
               // a paused charger carries no current, so no release then
               if (running && i_sense.current_below_tenth) begin
                  next_released = 1'b1;
               end
            end
         end
         cse_pkg::CSE_TERM: begin
            if (!enabled) begin
               next_state = cse_pkg::CSE_IDLE;
            end
         end
         cse_pkg::CSE_BAD: begin
            if (!enabled) begin
               next_state = cse_pkg::CSE_IDLE;
            end else if (!i_sense.vbat_below_trickle) begin
               next_state       = cse_pkg::CSE_CHARGE;
               next_trickle_cnt = '0;
            end
         end
         default: begin
            next_state = cse_pkg::CSE_IDLE;
         end
      endcase

      next_charge_on  = (next_state == cse_pkg::CSE_CHARGE) && running;
      next_trickle_on = next_charge_on && i_sense.vbat_below_trickle;
      next_reduce_on  = next_charge_on && i_sense.die_hot;

      next_pin_mode = cse_pkg::PIN_HIZ;
      if (!next_released) begin
         if (next_state == cse_pkg::CSE_BAD) begin
            next_pin_mode = cse_pkg::PIN_BAD;
         end else if (next_state == cse_pkg::CSE_CHARGE) begin
            next_pin_mode = temp_fault ? cse_pkg::PIN_TEMP : cse_pkg::PIN_LOW;
         end
      end

      blink_last = ((pin_mode == cse_pkg::PIN_TEMP) ? TEMP_HALF_P : BAD_HALF_P) - 32'h1;
      next_slot_cnt   = slot_cnt;
      next_step_cnt   = step_cnt;
      next_blink_cnt  = blink_cnt;
      next_blink_half = blink_half;
      if (next_pin_mode != pin_mode) begin
         next_slot_cnt   = '0;
         next_step_cnt   = 4'h0;
         next_blink_cnt  = '0;
         next_blink_half = 1'b0;
      end else begin
         if (slot_cnt == SLOT_LAST) begin
            next_slot_cnt = '0;
            next_step_cnt = step_cnt + 4'h1;
         end else begin
            next_slot_cnt = slot_cnt + 8'h01;
         end
         if (blink_cnt >= blink_last) begin
            // halves change only at a carrier boundary, so no cut pulse
            if ((slot_cnt == SLOT_LAST) && (step_cnt == 4'hf)) begin
               next_blink_cnt  = '0;
               next_blink_half = !blink_half;
            end
         end else begin
            next_blink_cnt = blink_cnt + 32'h1;
         end
      end

      case (next_pin_mode)
         cse_pkg::PIN_LOW: begin
            next_pin_oe = 1'b1;
         end
         cse_pkg::PIN_TEMP, cse_pkg::PIN_BAD: begin
            next_pin_oe = next_step_cnt < cse_duty(next_pin_mode, next_blink_half);
         end
         default: begin
            next_pin_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state       <= cse_pkg::CSE_IDLE;
         pin_mode    <= cse_pkg::PIN_HIZ;
         released    <= 1'b0;
         bad_latch   <= 1'b0;
         safety_cnt  <= '0;
         trickle_cnt <= '0;
         slot_cnt    <= '0;
         step_cnt    <= 4'h0;
         blink_cnt   <= '0;
         blink_half  <= 1'b0;
         pin_oe      <= 1'b0;
         charge_on   <= 1'b0;
         trickle_on  <= 1'b0;
         reduce_on   <= 1'b0;
      end else begin
         state       <= next_state;
         pin_mode    <= next_pin_mode;
         released    <= next_released;
         bad_latch   <= next_bad_latch;
         safety_cnt  <= next_safety_cnt;
         trickle_cnt <= next_trickle_cnt;
         slot_cnt    <= next_slot_cnt;
         step_cnt    <= next_step_cnt;
         blink_cnt   <= next_blink_cnt;
         blink_half  <= next_blink_half;
         pin_oe      <= next_pin_oe;
         charge_on   <= next_charge_on;
         trickle_on  <= next_trickle_on;
         reduce_on   <= next_reduce_on;
      end
   end

   always_comb begin
      status_word = 32'h0;
      status_word[cse_pkg::ST_STATE_LSB +: 2] = state;
      status_word[cse_pkg::ST_PIN_LSB +: 2]   = pin_mode;
      status_word[cse_pkg::ST_RELEASED_BIT]   = released;
      status_word[cse_pkg::ST_BADLATCH_BIT]   = bad_latch;
      status_word[cse_pkg::ST_TEMPFLT_BIT]    = temp_fault;
      status_word[cse_pkg::ST_CHARGE_BIT]     = charge_on;
      status_word[cse_pkg::ST_TRICKLE_BIT]    = trickle_on;
      status_word[cse_pkg::ST_REDUCE_BIT]     = reduce_on;
      next_ctrl_hold = ctrl_hold;
      next_pready    = 1'b0;
      next_prdata    = prdata;
      next_pslverr   = 1'b0;
      // one wait state: answer prepared in the first access cycle
      if (i_psel && i_penable && !pready) begin
         next_pready  = 1'b1;
         next_pslverr = !cse_reg_known(i_paddr);
         next_prdata  = 32'h0;
         if (!i_pwrite) begin
            case (i_paddr)
               cse_pkg::REG_CTRL: begin
                  next_prdata[cse_pkg::CTRL_HOLD_BIT] = ctrl_hold;
               end
               cse_pkg::REG_STATUS: begin
                  next_prdata = status_word;
               end
               cse_pkg::REG_TIMER: begin
                  next_prdata = safety_cnt[31:0];
               end
               default: begin
                  next_prdata = 32'h0;
               end
            endcase
         end
      end
      if (i_psel && i_penable && pready && i_pwrite && i_paddr == cse_pkg::REG_CTRL) begin
         next_ctrl_hold = i_pwdata[cse_pkg::CTRL_HOLD_BIT];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_hold <= cse_pkg::CTRL_HOLD_RESET;
         pready    <= 1'b0;
         prdata    <= 32'h0;
         pslverr   <= 1'b0;
      end else begin
         ctrl_hold <= next_ctrl_hold;
         pready    <= next_pready;
         prdata    <= next_prdata;
         pslverr   <= next_pslverr;
      end
   end

   assign o_pready                  = pready;
   assign o_prdata                  = prdata;
   assign o_pslverr                 = pslverr;
   assign o_charge_status_output_o  = 1'b0;
   assign o_charge_status_output_oe = pin_oe;
   assign o_charge_on               = charge_on;
   assign o_trickle_current         = trickle_on;
   assign o_current_reduce          = reduce_on;

endmodule

// [testbench/cse_chk_sva.sv]
`timescale 1ns/100ps
module cse_chk (
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   input  wire cse_pkg::cse_sense_t i_sense,
   input  wire logic                i_psel,
   input  wire logic                i_penable,
   input  wire logic [7:0]          i_paddr,
   input  wire logic                o_pready,
   input  wire logic                o_pslverr,
   input  wire logic                o_charge_status_output_o,
   input  wire logic                o_charge_status_output_oe,
   input  wire logic                o_charge_on,
   input  wire logic                o_trickle_current,
   input  wire logic                o_current_reduce
);
   // drive run length, and temp fault held over the whole run
   logic [15:0] hi_len;
   logic [15:0] next_hi_len;
   logic        tf_run;
   logic        next_tf_run;
   logic        tf;
   always_comb begin
      tf          = (i_sense.hot_trip | i_sense.cold_trip) & ~i_sense.thermistor_grounded;
      next_hi_len = o_charge_status_output_oe ? hi_len + 16'h0001 : 16'h0000;
      next_tf_run = tf & (tf_run | ~o_charge_status_output_oe);
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         hi_len <= 16'h0000;
         tf_run <= 1'b0;
      end else begin
         hi_len <= next_hi_len;
         tf_run <= next_tf_run;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_od_data_low: assert property (o_charge_status_output_o == 1'b0)
      else $error("status data not low");
   a_apb_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("pready late");
   a_pready_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready too long");
   a_slverr_map: assert property (o_pready |-> o_pslverr == !(i_paddr inside {8'h00, 8'h04, 8'h08}))
      else $error("pslverr wrong");
   a_trickle_cause: assert property (o_trickle_current == (o_charge_on && $past(i_sense.vbat_below_trickle)))
      else $error("trickle wrong");
   a_reduce_cause: assert property (o_current_reduce == (o_charge_on && $past(i_sense.die_hot)))
      else $error("reduce wrong");
   a_temp_pause: assert property ($past(tf) |-> !o_charge_on)
      else $error("charge during temp fault");
   a_release_tenth: assert property (o_charge_on && i_sense.current_below_tenth && !tf && !i_sense.vbat_below_trickle |-> ##[1:2] !o_charge_status_output_oe)
      else $error("pin not released");
   a_charge_start: assert property ($rose(i_sense.power_good) && !i_sense.charger_suspend_input |-> ##[1:2] o_charge_status_output_oe)
      else $error("pin not low at start");
   a_temp_duty: assert property ($fell(o_charge_status_output_oe) && tf_run |-> hi_len == 16'h00df || hi_len == 16'h0d11)
      else $error("temp pulse length wrong");
endmodule
bind cse_top cse_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_sense(i_sense), .i_psel(i_psel),
   .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_charge_status_output_o(o_charge_status_output_o), .o_charge_status_output_oe(o_charge_status_output_oe),
   .o_charge_on(o_charge_on), .o_trickle_current(o_trickle_current), .o_current_reduce(o_current_reduce));

// [testbench/cse_led_mon.sv]
`timescale 1ns/100ps
module cse_led_mon (
   input  wire logic        i_clk,
   input  wire logic        i_oe,
   input  wire logic        i_o,
   output logic [15:0]      o_low_len,
   output logic [15:0]      o_high_len,
   output logic             o_reject
);
   logic        pin_q = 1'b1;
   logic [15:0] run = 16'h0000;
   wire         pin = i_oe ? i_o : 1'b1;
   initial begin
      o_low_len = 16'h0000;
      o_high_len = 16'h0000;
   end
   // last complete low and high run of the pulled-up pin
   always @(posedge i_clk) begin
      if (pin != pin_q) begin
         if (pin_q) o_high_len <= run;
         else o_low_len <= run;
         run <= 16'h0001;
      end else run <= run + 16'h0001;
      pin_q <= pin;
   end
   // equal runs mean a reading across a blink edge
   assign o_reject = (o_low_len == o_high_len);
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   logic                i_clk = 1'b0;
   logic                i_rst = 1'b1;
   cse_pkg::cse_sense_t sense;
   logic                psel, pen, pwr, pready, pslverr, od, oe, chg, trk, red, err, acc, dh, vb, rej;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd, t0;
   logic [15:0]         lo_len, hi_len;
   int                  failures = 0;
   int                  n_checks = 0;
   int                  cyc = 0;
   integer              seed = 32'h51dce587;
   cse_top #(.SAFETY_CYCLES_P(42'h7d0), .BAD_CYCLES_P(42'h1f4), .TEMP_HALF_P(32'h3e80), .BAD_HALF_P(32'h1f40)) uut (
      .i_clk(i_clk), .i_rst(i_rst), .i_sense(sense), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .o_charge_status_output_o(od), .o_charge_status_output_oe(oe), .o_charge_on(chg),
      .o_trickle_current(trk), .o_current_reduce(red));
   cse_led_mon mon (.i_clk(i_clk), .i_oe(oe), .i_o(od), .o_low_len(lo_len), .o_high_len(hi_len), .o_reject(rej));
   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures = failures + 1;
         final_report;
      end
   end
   task final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; pen <= 1'b0;
      @(posedge i_clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; pen <= 1'b0;
      chk("apb wait", 32'h2, n);
   endtask
   function logic [31:0] steps(input logic [3:0] d);
      return cse_pkg::SLOT_CYCLES[31:0] * {28'h0, d};
   endfunction
   function logic [31:0] st(input logic [1:0] s, input logic [1:0] p, input logic c);
      return {24'h0, c, 3'h0, p, s};
   endfunction
   task pwm(input logic [3:0] d);
      chk("pin low run", steps(d), {16'h0, lo_len});
      chk("pin high run", steps(4'h0 - d), {16'h0, hi_len});
      chk("no reject", 32'h0, {31'h0, rej});
   endtask
   initial begin
      sense = '0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      wt(2);
      i_rst <= 1'b0;
      apb(1'b0, cse_pkg::REG_STATUS, 32'h0); chk("status idle", 32'h0, rd);
      apb(1'b0, cse_pkg::REG_CTRL, 32'h0); chk("ctrl reset", 32'h0, rd);
      apb(1'b1, 8'h0c, 32'h1); chk("slverr", 32'h1, {31'h0, err});
      apb(1'b0, 8'h0c, 32'h0); chk("unmapped", 32'h0, rd);
      sense.power_good <= 1'b1;
      wt(3);
      chk("oe start", 32'h1, {31'h0, oe});
      apb(1'b0, cse_pkg::REG_STATUS, 32'h0); chk("status charge", st(2'h1, 2'h1, 1'b1), rd & 32'h8f);
      for (int i = 0; i < 100; i++) begin
         {dh, vb} = 2'($random(seed));
         sense.die_hot <= dh;
         sense.vbat_below_trickle <= vb;
         wt(2);
         chk("reduce", {31'h0, dh}, {31'h0, red});
         chk("trickle", {31'h0, vb}, {31'h0, trk});
      end
      sense.die_hot <= 1'b0; sense.vbat_below_trickle <= 1'b0;
      apb(1'b1, cse_pkg::REG_CTRL, 32'h1);
      apb(1'b0, cse_pkg::REG_TIMER, 32'h0); t0 = rd;
      wt(50);
      apb(1'b0, cse_pkg::REG_TIMER, 32'h0); chk("timer held", t0, rd);
      chk("paused", 32'h0, {31'h0, chg});
      apb(1'b1, cse_pkg::REG_CTRL, 32'h0);
      sense.cv_mode <= 1'b1; sense.hot_trip <= 1'b1;
      wt(7000);
      pwm(cse_pkg::TEMP_DUTY_LO);
      chk("hot pause", 32'h0, {31'h0, chg});
      wt(16300);
      pwm(cse_pkg::TEMP_DUTY_HI);
      apb(1'b0, cse_pkg::REG_TIMER, 32'h0); t0 = rd;
      wt(20);
      apb(1'b0, cse_pkg::REG_TIMER, 32'h0); chk("timer frozen", t0, rd);
      sense.hot_trip <= 1'b0; sense.cold_trip <= 1'b1;
      wt(5);
      chk("cold pause", 32'h0, {31'h0, chg});
      sense.thermistor_grounded <= 1'b1;
      wt(300);
      chk("ground charge", 32'h1, {31'h0, chg & oe});
      sense.thermistor_grounded <= 1'b0; sense.cold_trip <= 1'b0; sense.cv_mode <= 1'b0;
      wt(5);
      sense.current_below_tenth <= 1'b1;
      wt(4);
      chk("released", 32'h0, {31'h0, oe});
      sense.hot_trip <= 1'b1;
      acc = 1'b0;
      repeat (4000) begin
         @(posedge i_clk);
         acc = acc | oe;
      end
      chk("fault after release", 32'h0, {31'h0, acc});
      sense.power_good <= 1'b0; sense.hot_trip <= 1'b0; sense.current_below_tenth <= 1'b0;
      wt(3);
      sense.power_good <= 1'b1; sense.vbat_below_trickle <= 1'b1;
      wt(450);
      chk("trickle run", 32'h1, {31'h0, chg});
      wt(70);
      chk("bad stop", 32'h0, {31'h0, chg});
      wt(6500);
      pwm(cse_pkg::BAD_DUTY_LO);
      wt(7500);
      chk("blink edge reject", 32'h1, {31'h0, rej});
      wt(500);
      pwm(cse_pkg::BAD_DUTY_HI);
      apb(1'b0, cse_pkg::REG_STATUS, 32'h0); chk("status bad", 32'h23, rd & 32'h23);
      sense.vbat_below_trickle <= 1'b0;
      wt(5);
      chk("resume", 32'h1, {31'h0, chg});
      sense.vbat_below_trickle <= 1'b1;
      wt(3);
      chk("bad again", 32'h0, {31'h0, chg});
      sense.charger_suspend_input <= 1'b1;
      wt(3);
      sense.charger_suspend_input <= 1'b0;
      wt(100);
      chk("latch cleared", 32'h1, {31'h0, chg});
      final_report;
   end
endmodule
